// ==== shared/rmc_pkg.sv ====
// Purpose: shared constants and types for the reader mode control registers
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: byte address is four times the register index

`default_nettype none

package rmc_pkg;

	localparam int ADDR_W = 8;

	// register indices and byte addresses
	localparam logic [ADDR_W-1:0] OPCTRL_IDX = 8'h02;
	localparam logic [ADDR_W-1:0] MODE_IDX = 8'h03;
	localparam logic [ADDR_W-1:0] RATE_IDX = 8'h04;
	localparam logic [ADDR_W-1:0] OPCTRL_ADDR = 8'(OPCTRL_IDX << 2);
	localparam logic [ADDR_W-1:0] MODE_ADDR = 8'(MODE_IDX << 2);
	localparam logic [ADDR_W-1:0] RATE_ADDR = 8'(RATE_IDX << 2);

	// operation control fields
	localparam int OC_EN_BIT = 7;
	localparam int OC_RX_EN_BIT = 6;
	localparam int OC_RX_ONE_CH_BIT = 5;
	localparam int OC_RX_MANUAL_BIT = 4;
	localparam int OC_TX_EN_BIT = 3;
	localparam int OC_WAKEUP_BIT = 2;
	localparam logic [7:0] OC_WRITE_MASK = 8'hFC;

	// mode definition fields
	localparam int MD_TARGET_BIT = 7;
	localparam int MD_OM_LSB = 3;
	localparam int MD_AUTO_RCA_BIT = 0;
	localparam logic [7:0] MD_WRITE_MASK = 8'hF9;

	// bit rate fields
	localparam int BR_TX_LSB = 4;
	localparam int BR_RX_LSB = 0;

	// reset values
	localparam logic [7:0] OC_RESET = 8'h00;
	localparam logic [7:0] MD_RESET = 8'h08;
	localparam logic [7:0] BR_RESET = 8'h00;

	// operating mode codes
	localparam logic [3:0] OM_ACTIVE_P2P = 4'h0;
	localparam logic [3:0] OM_TYPE_A = 4'h1;
	localparam logic [3:0] OM_TYPE_B = 4'h2;
	localparam logic [3:0] OM_TYPE_F = 4'h3;
	localparam logic [3:0] OM_TYPE_1_TAG = 4'h4;
	localparam logic [3:0] OM_SUBC_STREAM = 4'hE;
	localparam logic [3:0] OM_BPSK_STREAM = 4'hF;
	localparam logic [3:0] OM_TGT_RATE_DETECT = 4'h0;
	localparam logic [3:0] OM_TGT_NORMAL = 4'h1;

	// rate codes: fc/128, fc/64, fc/32, fc/16
	localparam logic [3:0] RATE_MAX_CODE = 4'h3;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} rmc_wr_t;

	typedef struct packed {
		logic am_en;
		logic pm_en;
		logic auto_sel;
		logic pick;
	} rmc_chan_t;

	function automatic logic rmc_addr_ok(input logic [ADDR_W-1:0] a);
		return (a == OPCTRL_ADDR) || (a == MODE_ADDR) || (a == RATE_ADDR);
	endfunction : rmc_addr_ok

endpackage : rmc_pkg

`default_nettype wire

// ==== core/rmc_axil_slave.sv ====
// Purpose: AXI4-Lite slave front end for the mode control registers
// Assumes: one write and one read under way at a time
// Notes: write issues in the same cycle that both halves are held, one cycle after they are taken

`timescale 1ns/1ps
`default_nettype none

module rmc_axil_slave (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [rmc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [rmc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output rmc_pkg::rmc_wr_t wr_req,
	output logic [rmc_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data
);

	logic aw_full_q, w_full_q, aw_full_d, w_full_d, bvalid_d;
	logic aw_take, w_take, ar_take, do_wr;

	assign aw_take = awvalid && awready;
	assign w_take = wvalid && wready;
	assign ar_take = arvalid && arready;
	assign do_wr = aw_full_q && w_full_q && !bvalid;
	assign aw_full_d = do_wr ? 1'b0 : (aw_full_q || aw_take);
	assign w_full_d = do_wr ? 1'b0 : (w_full_q || w_take);
	assign bvalid_d = do_wr || (bvalid && !bready);
	assign wr_en = do_wr;
	assign rd_addr = araddr;

	////////////////////////////////////////////////////////////////////////
	// write channels: address and data taken in either order
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= rmc_pkg::RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			// ready drops while a half waits, so nothing is overwritten
			awready <= !aw_full_d && !bvalid_d;
			wready <= !w_full_d && !bvalid_d;
			bvalid <= bvalid_d;
			if (do_wr) begin
				bresp <= rmc_pkg::rmc_addr_ok(wr_req.addr) ?
					rmc_pkg::RESP_OKAY : rmc_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_req <= '0;
		end else begin
			if (aw_take) begin
				wr_req.addr <= awaddr;
			end
			if (w_take) begin
				wr_req.data <= wdata;
				wr_req.strb <= wstrb;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel: data sampled on the address edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= rmc_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				rvalid <= 1'b1;
				rdata <= rd_data;
				rresp <= rmc_pkg::rmc_addr_ok(araddr) ?
					rmc_pkg::RESP_OKAY : rmc_pkg::RESP_SLVERR;
				arready <= 1'b0;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end else begin
				arready <= !rvalid;
			end
		end
	end

endmodule : rmc_axil_slave

`default_nettype wire

// ==== core/rmc_regs.sv ====
// Purpose: operation control, mode and bit rate registers of the front end
// Assumes: rst_n is the power-up reset; command inputs are one-cycle pulses
// Notes: hardware setting of the transmit enable wins over any clear

`timescale 1ns/1ps
`default_nettype none

module rmc_regs (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [rmc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [rmc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic cmd_field_on,
	input wire logic cmd_set_default,
	input wire logic cmd_normal_p2p,
	input wire logic [3:0] detected_rate,
	input wire logic tx_finished,
	input wire logic ext_field_off,
	input wire logic channel_choice,
	output logic osc_reg_enable,
	output logic rx_enable,
	output logic tx_enable,
	output logic wakeup_enable,
	output rmc_pkg::rmc_chan_t rx_channel,
	output logic target_role,
	output logic [3:0] operating_mode_code,
	output logic [3:0] transmit_rate_code,
	output logic [3:0] receive_rate_code,
	output logic auto_response_collision_avoid,
	output logic rca_start
);

	logic [7:0] opctrl_q, mode_q, rate_q;
	logic wr_en;
	rmc_pkg::rmc_wr_t wr_req;
	logic [rmc_pkg::ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic wr_lane0;
	logic wr_opctrl, wr_mode, wr_rate;
	logic mode_ok, rates_ok, ops_ok, active_p2p, split_rates;
	logic [3:0] om_code, tx_code, rx_code, rx_code_eff;

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic mode_legal(input logic tgt, input logic [3:0] om);
		if (tgt) begin
			return (om == rmc_pkg::OM_TGT_RATE_DETECT) ||
				(om == rmc_pkg::OM_TGT_NORMAL);
		end
		return (om == rmc_pkg::OM_ACTIVE_P2P) || (om == rmc_pkg::OM_TYPE_A) ||
			(om == rmc_pkg::OM_TYPE_B) || (om == rmc_pkg::OM_TYPE_F) ||
			(om == rmc_pkg::OM_TYPE_1_TAG) ||
			(om == rmc_pkg::OM_SUBC_STREAM) ||
			(om == rmc_pkg::OM_BPSK_STREAM);
	endfunction : mode_legal

	function automatic logic rate_legal(input logic [3:0] code);
		return code <= rmc_pkg::RATE_MAX_CODE;
	endfunction : rate_legal

	////////////////////////////////////////////////////////////////////////
	// bus front end

	rmc_axil_slave u_bus (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_req(wr_req),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// registers are one byte wide; a write without lane 0 changes nothing
	assign wr_lane0 = wr_en && wr_req.strb[0];
	assign wr_opctrl = wr_lane0 && (wr_req.addr == rmc_pkg::OPCTRL_ADDR);
	assign wr_mode = wr_lane0 && (wr_req.addr == rmc_pkg::MODE_ADDR);
	assign wr_rate = wr_lane0 && (wr_req.addr == rmc_pkg::RATE_ADDR);

	always_comb begin
		rd_data = 32'h0000_0000;
		if (rd_addr == rmc_pkg::OPCTRL_ADDR) begin
			rd_data[7:0] = opctrl_q;
		end else if (rd_addr == rmc_pkg::MODE_ADDR) begin
			rd_data[7:0] = mode_q;
		end else if (rd_addr == rmc_pkg::RATE_ADDR) begin
			rd_data[7:0] = rate_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field views

	assign om_code = mode_q[rmc_pkg::MD_OM_LSB +: 4];
	assign tx_code = rate_q[rmc_pkg::BR_TX_LSB +: 4];
	assign rx_code = rate_q[rmc_pkg::BR_RX_LSB +: 4];
	assign mode_ok = mode_legal(mode_q[rmc_pkg::MD_TARGET_BIT], om_code);
	// peer modes of either role clear transmit after each frame
	assign active_p2p = mode_q[rmc_pkg::MD_TARGET_BIT] ? mode_ok :
		(om_code == rmc_pkg::OM_ACTIVE_P2P);
	// only the Type A and Type B reader modes run asymmetric rates
	assign split_rates = !mode_q[rmc_pkg::MD_TARGET_BIT] &&
		((om_code == rmc_pkg::OM_TYPE_A) || (om_code == rmc_pkg::OM_TYPE_B));
	assign rx_code_eff = split_rates ? rx_code : tx_code;
	assign rates_ok = rate_legal(tx_code) && rate_legal(rx_code_eff);
	assign ops_ok = mode_ok && rates_ok;

	////////////////////////////////////////////////////////////////////////
	// operation control register

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			opctrl_q <= rmc_pkg::OC_RESET;
		end else begin
			// set default leaves this register alone
			if (wr_opctrl) begin
				opctrl_q <= wr_req.data[7:0] & rmc_pkg::OC_WRITE_MASK;
			end else if (tx_finished && active_p2p) begin
				opctrl_q[rmc_pkg::OC_TX_EN_BIT] <= 1'b0;
			end
			// the field-on set must win over a clear in the same cycle
			if (cmd_field_on) begin
				opctrl_q[rmc_pkg::OC_TX_EN_BIT] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode definition register

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= rmc_pkg::MD_RESET;
		end else if (cmd_set_default) begin
			mode_q <= rmc_pkg::MD_RESET;
		end else if (wr_mode) begin
			mode_q <= wr_req.data[7:0] & rmc_pkg::MD_WRITE_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bit rate register

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rate_q <= rmc_pkg::BR_RESET;
		end else if (cmd_set_default) begin
			rate_q <= rmc_pkg::BR_RESET;
		end else if (cmd_normal_p2p) begin
			rate_q <= {detected_rate, detected_rate};
		end else if (wr_rate) begin
			rate_q <= wr_req.data[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered controls to the front end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_reg_enable <= 1'b0;
			rx_enable <= 1'b0;
			tx_enable <= 1'b0;
			wakeup_enable <= 1'b0;
		end else begin
			osc_reg_enable <= opctrl_q[rmc_pkg::OC_EN_BIT];
			rx_enable <= opctrl_q[rmc_pkg::OC_RX_EN_BIT] && ops_ok;
			tx_enable <= opctrl_q[rmc_pkg::OC_TX_EN_BIT] && ops_ok;
			wakeup_enable <= opctrl_q[rmc_pkg::OC_WAKEUP_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_channel <= '0;
		end else if (opctrl_q[rmc_pkg::OC_RX_ONE_CH_BIT]) begin
			// one channel: the choice bit names it, low is AM
			rx_channel.am_en <= !channel_choice;
			rx_channel.pm_en <= channel_choice;
			rx_channel.auto_sel <= 1'b0;
			rx_channel.pick <= channel_choice;
		end else begin
			rx_channel.am_en <= 1'b1;
			rx_channel.pm_en <= 1'b1;
			rx_channel.auto_sel <= !opctrl_q[rmc_pkg::OC_RX_MANUAL_BIT];
			rx_channel.pick <= channel_choice;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			target_role <= 1'b0;
			operating_mode_code <= rmc_pkg::MD_RESET[rmc_pkg::MD_OM_LSB +: 4];
			transmit_rate_code <= 4'h0;
			receive_rate_code <= 4'h0;
			auto_response_collision_avoid <= 1'b0;
			rca_start <= 1'b0;
		end else begin
			target_role <= mode_q[rmc_pkg::MD_TARGET_BIT];
			operating_mode_code <= om_code;
			transmit_rate_code <= tx_code;
			receive_rate_code <= rx_code_eff;
			auto_response_collision_avoid <= mode_q[rmc_pkg::MD_AUTO_RCA_BIT];
			// one pulse per detected field drop
			rca_start <= ext_field_off &&
				mode_q[rmc_pkg::MD_AUTO_RCA_BIT];
		end
	end

endmodule : rmc_regs

`default_nettype wire

// ==== dv/rmc_asserts.sv ====
// Purpose: port-level checks for rmc_regs
// Assumes: one clock, rst_n asynchronous active low
// Notes: register state is inferred from outputs only
`timescale 1ns/1ps
`default_nettype none
module rmc_asserts (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic channel_choice,
	input wire logic ext_field_off,
	input wire logic rx_enable,
	input wire logic tx_enable,
	input wire rmc_pkg::rmc_chan_t rx_channel,
	input wire logic target_role,
	input wire logic [3:0] operating_mode_code,
	input wire logic [3:0] transmit_rate_code,
	input wire logic [3:0] receive_rate_code,
	input wire logic rca_start
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	function automatic logic om_ok(logic t, logic [3:0] m);
		return t ? (m <= 4'h1) : (m <= 4'h4 || m >= 4'hE);
	endfunction : om_ok
	sequence wr_both;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_take;
		arvalid && arready;
	endsequence
	wr_latency_a: assert property (wr_both |=> !bvalid ##1 bvalid)
		else $error("write answer not on time");
	rd_latency_a: assert property (rd_take |=> rvalid)
		else $error("read answer not on time");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	rdata_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	// a single legality gate covers mode and both rate codes
	txrx_gate_a: assert property (tx_enable || rx_enable |->
		om_ok(target_role, operating_mode_code) &&
		transmit_rate_code <= 4'h3 && receive_rate_code <= 4'h3)
		else $error("tx or rx enabled in illegal setting");
	one_chan_a: assert property (rx_channel.am_en != rx_channel.pm_en |->
		rx_channel.pm_en == $past(channel_choice) && !rx_channel.auto_sel)
		else $error("single channel does not follow choice");
	both_pick_a: assert property (rx_channel.am_en && rx_channel.pm_en |->
		rx_channel.pick == $past(channel_choice))
		else $error("manual pick does not follow choice");
	rca_cause_a: assert property (rca_start |-> $past(ext_field_off))
		else $error("collision avoidance start without field off");
endmodule : rmc_asserts
////////////////////////////////////////////////////////////////////////////
bind rmc_regs rmc_asserts i_rmc_asserts (.sys_clk, .rst_n, .awvalid, .awready,
	.wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
	.rvalid, .rready, .channel_choice, .ext_field_off, .rx_enable, .tx_enable,
	.rx_channel, .target_role, .operating_mode_code, .transmit_rate_code,
	.receive_rate_code, .rca_start);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for rmc_regs
// Assumes: AXI4-Lite master, 50 ns clock
// Notes: commands are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] OA = rmc_pkg::OPCTRL_ADDR;
	localparam logic [7:0] MA = rmc_pkg::MODE_ADDR;
	localparam logic [7:0] RA = rmc_pkg::RATE_ADDR;
	localparam logic [1:0] SLV = rmc_pkg::RESP_SLVERR;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0, det = 4'h0, trc, rrc, omc;
	logic [1:0] bresp, rresp;
	logic [4:0] cmd = 5'h00;
	logic cc = 1'b0, fired = 1'b0, rvalid, osc, rxe, txe, wke, targ, arc, rca;
	rmc_pkg::rmc_chan_t chan;
	int error_cnt = 0, checks_done = 0;
	always #25 sys_clk = ~sys_clk;
	rmc_regs i_rmc_regs (.sys_clk, .rst_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.cmd_field_on(cmd[0]), .cmd_set_default(cmd[1]),
		.cmd_normal_p2p(cmd[2]), .detected_rate(det), .tx_finished(cmd[3]),
		.ext_field_off(cmd[4]), .channel_choice(cc), .osc_reg_enable(osc),
		.rx_enable(rxe), .tx_enable(txe), .wakeup_enable(wke),
		.rx_channel(chan), .target_role(targ), .operating_mode_code(omc),
		.transmit_rate_code(trc), .receive_rate_code(rrc),
		.auto_response_collision_avoid(arc), .rca_start(rca));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	// outputs are read just after an edge, before that edge's updates land
	// extra edge at the end lets the outputs catch up with the register
	task automatic wr(input logic [7:0] a, d, input logic [3:0] s = 4'hF,
		input logic [1:0] e = rmc_pkg::RESP_OKAY);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk({bvalid, bresp}, {1'b1, e});
		bready <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] x,
		input logic [1:0] e = rmc_pkg::RESP_OKAY);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		chk({rvalid, rresp}, {1'b1, e});
		chk(rdata, x);
		rready <= 1'b0;
		@(posedge sys_clk);
	endtask : rdc
	// the start pulse shows one edge after the command edge
	task automatic pulse(input logic [4:0] v);
		cmd <= v;
		@(posedge sys_clk);
		cmd <= 5'h00;
		@(posedge sys_clk);
		fired = rca;
		@(posedge sys_clk);
	endtask : pulse
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({targ, omc}, 5'h01);
		chk({osc, rxe, txe, wke}, 4'h0);
		rdc(OA, 32'h00);
		rdc(MA, 32'h08);
		rdc(RA, 32'h00);
		rdc(8'h00, 32'h00, SLV);
		wr(8'h14, 8'hFF, 4'hF, SLV);
	endtask : t_reset
	task automatic t_ctrl();
		wr(OA, 8'hFF);
		chk({osc, rxe, txe, wke}, 4'hF);
		rdc(OA, 32'hFC);
		cc <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(chan, 4'h5);
		wr(OA, 8'h84);
		chk({osc, rxe, txe, wke, chan}, 8'h9F);
		wr(OA, 8'h10);
		chk({osc, chan}, 5'h0D);
		wr(OA, 8'h00, 4'h0);
		rdc(OA, 32'h10);
	endtask : t_ctrl
	task automatic t_mode();
		logic [3:0] m;
		logic t;
		logic ok;
		wr(OA, 8'hC8);
		for (int i = 0; i < 32; i++) begin
			t = i[4];
			m = i[3:0];
			ok = t ? (m <= 4'h1) : (m <= 4'h4 || m >= 4'hE);
			wr(MA, {t, m, 3'b110});
			chk({targ, omc}, {t, m});
			chk({rxe, txe}, {ok, ok});
			rdc(MA, {24'h0, t, m, 3'b000});
		end
	endtask : t_mode
	task automatic t_rate();
		logic [7:0] v;
		wr(MA, 8'h08);
		for (int i = 0; i < 32; i++) begin
			v = i[4] ? {i[3:0], 4'h0} : {4'h0, i[3:0]};
			wr(RA, v);
			chk({trc, rrc}, v);
			chk(txe, i[3:0] <= 4'h3);
		end
		wr(MA, 8'h18);
		wr(RA, 8'h05);
		chk({trc, rrc, txe}, 9'h001);
	endtask : t_rate
	task automatic t_cmd();
		wr(MA, 8'h81);
		wr(RA, 8'h33);
		pulse(5'h02);
		rdc(MA, 32'h08);
		rdc(RA, 32'h00);
		rdc(OA, 32'hC8);
		det <= 4'h2;
		pulse(5'h04);
		rdc(RA, 32'h22);
		wr(OA, 8'h80);
		pulse(5'h01);
		chk(txe, 1'b1);
		pulse(5'h08);
		rdc(OA, 32'h88);
		wr(MA, 8'h00);
		pulse(5'h08);
		rdc(OA, 32'h80);
		pulse(5'h10);
		chk(fired, 1'b0);
		wr(MA, 8'h01);
		chk(arc, 1'b1);
		pulse(5'h10);
		chk(fired, 1'b1);
	endtask : t_cmd
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_reset();
		t_ctrl();
		t_mode();
		t_rate();
		t_cmd();
		conclude();
	end
	// full run needs about 480 cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		conclude();
	end
endmodule : tb_top
`default_nettype wire
